// file: icr_map.svh
// register offsets, field positions and reset values of the clear block
`ifndef ICR_MAP_SVH
`define ICR_MAP_SVH
`define ICR_OFF_CLR_ALL 8'h40
`define ICR_OFF_CLR_RXU 8'h44
`define ICR_OFF_CLR_RXO 8'h48
`define ICR_OFF_CLR_TXO 8'h4c
`define ICR_OFF_CLR_RDQ 8'h50
`define ICR_OFF_CLR_ABT 8'h54
`define ICR_OFF_CLR_RXD 8'h58
`define ICR_OFF_CLR_ACT 8'h5c
`define ICR_OFF_RAW 8'h80
`define ICR_OFF_MASK 8'h84
`define ICR_OFF_ABT_SRC 8'h88
`define ICR_BIT_RXU 0
`define ICR_BIT_RXO 1
`define ICR_BIT_RXF 2
`define ICR_BIT_TXO 3
`define ICR_BIT_TXE 4
`define ICR_BIT_RDQ 5
`define ICR_BIT_ABT 6
`define ICR_BIT_RXD 7
`define ICR_BIT_ACT 8
`define ICR_SW_BITS 9'h1eb
`define ICR_ABT_KEEP_BIT 9
`define ICR_RAW_RST 9'h000
`define ICR_MASK_RST 9'h000
`define ICR_ABT_RST 32'h00000000
`define ICR_RDATA_RST 32'h00000000
`endif

// file: icr_pkg.sv
// types shared by the interrupt clear block
package icr_pkg;
  typedef logic [8:0] icr_raw_t;
  typedef logic [31:0] icr_word_t;
  typedef logic [7:0] icr_addr_t;
  typedef enum logic [1:0] {
    ICR_BUS_IDLE = 2'b00,
    ICR_BUS_ACK = 2'b01
  } icr_bus_e;
endpackage

// file: icr_sticky.sv
// sticky flag vector: set wins over clear
module icr_sticky #(
  parameter int W = 9,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // set and clear vectors
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  // flags
  output logic [W-1:0] o_q
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  // an event in the clearing cycle is never lost
  assign q_nxt = (q_r & ~i_clr) | i_set;
  assign o_q = q_r;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

// file: icr_bus_if.sv
// avalon-mm handshake: one wait state per access
module icr_bus_if
  import icr_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // request strobes
  input wire logic i_read,
  input wire logic i_write,
  // handshake and access phases
  output logic o_waitrequest,
  output logic o_capture,
  output logic o_rd_done,
  output logic o_wr_done
);
  icr_bus_e state_r;
  icr_bus_e state_nxt;
  wire req = i_read | i_write;
  wire idle = (state_r == ICR_BUS_IDLE);
  assign state_nxt = (idle && req) ? ICR_BUS_ACK : ICR_BUS_IDLE;
  // wait state lets read data be registered before the clear lands
  assign o_waitrequest = req & idle;
  assign o_capture = i_read & idle;
  assign o_rd_done = i_read & ~idle;
  assign o_wr_done = i_write & ~idle;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= ICR_BUS_IDLE;
    end else begin
      case (state_r)
        ICR_BUS_IDLE: state_r <= state_nxt;
        ICR_BUS_ACK: state_r <= state_nxt;
        default: state_r <= ICR_BUS_IDLE;
      endcase
    end
  end
endmodule

// file: icr_top.sv
// read-to-clear interrupt registers of the two-wire controller
// Functional notes
// - clear-all read clears all software bits except activity while bus is active, and abort source record; irq stays set while a masked level bit is high
// - clear-all read leaves hardware-cleared status bits alone
// - bit 9 of abort source record is not wiped by clear reads while abort keep cause is set
// - receive-underflow clear read clears raw bit 0 only
// - receive-overflow clear read clears raw bit 1
// - transmit-overflow clear read clears raw bit 3
// - read-request clear read clears raw bit 5
// - transmit-abort clear read clears raw bit 6 and abort source record
// - transmit-abort clear read releases the flushed transmit fifo
// - receive-finished clear read clears raw bit 7
// - activity clear read clears flag only while bus is not active
// - activity flag self-clears when disabled and bus idle
// - activity clear read returns raw bit 8 in bit 0
// - receive-underflow flag sets on read of an empty receive buffer
`include "icr_map.svh"
module icr_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // avalon-mm slave
  input wire icr_pkg::icr_addr_t i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire icr_pkg::icr_word_t i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output icr_pkg::icr_word_t o_avs_readdata,
  output logic o_avs_waitrequest,
  // controller events, one-cycle pulses, with rx empty level and abort cause
  input wire logic i_rx_pop,
  input wire logic i_rx_empty,
  input wire logic i_rx_over_evt,
  input wire logic i_tx_over_evt,
  input wire logic i_rd_req_evt,
  input wire logic i_rx_done_evt,
  input wire logic i_abort_evt,
  input wire icr_pkg::icr_word_t i_abort_cause,
  // controller levels
  input wire logic i_rx_full_lvl,
  input wire logic i_tx_empty_lvl,
  input wire logic i_bus_active,
  input wire logic i_enable,
  input wire logic i_abort_keep_cause,
  // status out
  output icr_pkg::icr_raw_t o_raw_status,
  output icr_pkg::icr_word_t o_abort_source,
  output logic o_tx_flush_hold,
  output logic o_irq
);
  import icr_pkg::*;

  function automatic logic hit(input icr_addr_t a, input icr_addr_t off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  logic capture;
  logic rd_done;
  logic wr_done;
  icr_raw_t sticky_q;
  icr_raw_t raw_set;
  icr_raw_t raw_clr;
  icr_raw_t raw_view;
  icr_raw_t mask_r;
  icr_raw_t mask_nxt;
  icr_word_t abt_q;
  icr_word_t abt_set;
  icr_word_t abt_clr;
  icr_word_t rdata_r;
  icr_word_t rdata_nxt;
  logic flush_r;
  logic flush_nxt;

  icr_bus_if u_bus (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_read(i_avs_read),
    .i_write(i_avs_write),
    .o_waitrequest(o_avs_waitrequest),
    .o_capture(capture),
    .o_rd_done(rd_done),
    .o_wr_done(wr_done)
  );

  // address decode
  wire a_all = hit(i_avs_address, `ICR_OFF_CLR_ALL);
  wire a_rxu = hit(i_avs_address, `ICR_OFF_CLR_RXU);
  wire a_rxo = hit(i_avs_address, `ICR_OFF_CLR_RXO);
  wire a_txo = hit(i_avs_address, `ICR_OFF_CLR_TXO);
  wire a_rdq = hit(i_avs_address, `ICR_OFF_CLR_RDQ);
  wire a_abt = hit(i_avs_address, `ICR_OFF_CLR_ABT);
  wire a_rxd = hit(i_avs_address, `ICR_OFF_CLR_RXD);
  wire a_act = hit(i_avs_address, `ICR_OFF_CLR_ACT);
  wire a_raw = hit(i_avs_address, `ICR_OFF_RAW);
  wire a_msk = hit(i_avs_address, `ICR_OFF_MASK);
  wire a_src = hit(i_avs_address, `ICR_OFF_ABT_SRC);

  // clear side effects only on the completing read edge
  wire c_all = rd_done & a_all;
  wire c_rxu = rd_done & a_rxu;
  wire c_rxo = rd_done & a_rxo;
  wire c_txo = rd_done & a_txo;
  wire c_rdq = rd_done & a_rdq;
  wire c_abt = rd_done & a_abt;
  wire c_rxd = rd_done & a_rxd;
  wire c_act = rd_done & a_act;
  wire w_raw = wr_done & a_raw;
  wire w_msk = wr_done & a_msk;
  wire hw_idle_off = ~i_enable & ~i_bus_active;

  // sticky event bits
  wire rx_under = i_rx_pop & i_rx_empty;
  always_comb begin
    raw_set = '0;
    raw_set[`ICR_BIT_RXU] = rx_under;
    raw_set[`ICR_BIT_RXO] = i_rx_over_evt;
    raw_set[`ICR_BIT_TXO] = i_tx_over_evt;
    raw_set[`ICR_BIT_RDQ] = i_rd_req_evt;
    raw_set[`ICR_BIT_ABT] = i_abort_evt;
    raw_set[`ICR_BIT_RXD] = i_rx_done_evt;
    // activity re-sets while busy, so a clear read cannot drop it
    raw_set[`ICR_BIT_ACT] = i_bus_active;
  end

  always_comb begin
    raw_clr = '0;
    raw_clr[`ICR_BIT_RXU] = c_rxu;
    raw_clr[`ICR_BIT_RXO] = c_rxo;
    raw_clr[`ICR_BIT_TXO] = c_txo;
    raw_clr[`ICR_BIT_RDQ] = c_rdq;
    raw_clr[`ICR_BIT_ABT] = c_abt;
    raw_clr[`ICR_BIT_RXD] = c_rxd;
    raw_clr[`ICR_BIT_ACT] = c_act | hw_idle_off;
    if (c_all) begin
      raw_clr = raw_clr | `ICR_SW_BITS;
    end
    if (w_raw) begin
      raw_clr = raw_clr | (i_avs_writedata[8:0] & `ICR_SW_BITS);
    end
    // level bits are never held here
    raw_clr = raw_clr & `ICR_SW_BITS;
  end

  icr_sticky #(
    .W(9),
    .RST(`ICR_RAW_RST)
  ) u_raw (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_set(raw_set),
    .i_clr(raw_clr),
    .o_q(sticky_q)
  );

  // hardware-cleared levels pass straight through
  always_comb begin
    raw_view = sticky_q & `ICR_SW_BITS;
    raw_view[`ICR_BIT_RXF] = i_rx_full_lvl;
    raw_view[`ICR_BIT_TXE] = i_tx_empty_lvl;
  end

  // abort source record
  wire abt_wipe = c_all | c_abt;
  assign abt_set = i_abort_evt ? i_abort_cause : '0;
  always_comb begin
    abt_clr = abt_wipe ? '1 : '0;
    // kept bit drops only once its cause has gone
    if (i_abort_keep_cause) begin
      abt_clr[`ICR_ABT_KEEP_BIT] = 1'b0;
    end
  end

  icr_sticky #(
    .W(32),
    .RST(`ICR_ABT_RST)
  ) u_abt (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_set(abt_set),
    .i_clr(abt_clr),
    .o_q(abt_q)
  );

  // fifo stays flushed from abort until software acknowledges
  assign flush_nxt = i_abort_evt | (flush_r & ~abt_wipe);

  // mask, low byte lanes only
  assign mask_nxt = {i_avs_byteenable[1] ? i_avs_writedata[8] : mask_r[8],
                     i_avs_byteenable[0] ? i_avs_writedata[7:0]
                                         : mask_r[7:0]};

  // read mux, sampled before the clear lands
  always_comb begin
    rdata_nxt = '0;
    if (a_all) begin
      rdata_nxt[0] = o_irq;
    end else if (a_rxu) begin
      rdata_nxt[0] = raw_view[`ICR_BIT_RXU];
    end else if (a_rxo) begin
      rdata_nxt[0] = raw_view[`ICR_BIT_RXO];
    end else if (a_txo) begin
      rdata_nxt[0] = raw_view[`ICR_BIT_TXO];
    end else if (a_rdq) begin
      rdata_nxt[0] = raw_view[`ICR_BIT_RDQ];
    end else if (a_abt) begin
      rdata_nxt[0] = raw_view[`ICR_BIT_ABT];
    end else if (a_rxd) begin
      rdata_nxt[0] = raw_view[`ICR_BIT_RXD];
    end else if (a_act) begin
      rdata_nxt[0] = raw_view[`ICR_BIT_ACT];
    end else if (a_raw) begin
      rdata_nxt[8:0] = raw_view;
    end else if (a_msk) begin
      rdata_nxt[8:0] = mask_r;
    end else if (a_src) begin
      rdata_nxt = abt_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_r <= `ICR_RDATA_RST;
    end else if (capture) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_r <= `ICR_MASK_RST;
    end else if (w_msk) begin
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= flush_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_raw_status = raw_view;
  assign o_abort_source = abt_q;
  assign o_tx_flush_hold = flush_r;
  assign o_irq = |(raw_view & mask_r);

  // checks
  wire ev_any = rx_under | i_rx_over_evt | i_tx_over_evt | i_rd_req_evt
              | i_rx_done_evt | i_abort_evt;

  a_clr_all_bits: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    c_all && !ev_any && !i_bus_active
    |=> (o_raw_status & `ICR_SW_BITS) == 9'h000
        && (!o_irq || (o_raw_status & mask_r & 9'h014) != 9'h000))
    else $error("clear-all left software bits set");

  a_hw_bits_pass: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    c_all |-> o_raw_status[`ICR_BIT_RXF] == i_rx_full_lvl
          && o_raw_status[`ICR_BIT_TXE] == i_tx_empty_lvl)
    else $error("hardware level bit disturbed");

  a_abort_keep_bit: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    abt_wipe && i_abort_keep_cause && o_abort_source[9]
    |=> o_abort_source[9])
    else $error("kept abort source bit was wiped");

  a_abort_src_wipe: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    abt_wipe && !i_abort_evt && !i_abort_keep_cause
    |=> o_abort_source == 32'h00000000)
    else $error("abort source not wiped");

  a_rx_under_clr: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    c_rxu && !rx_under
    |=> !o_raw_status[0]
        && ((o_raw_status[8:1] | ~$past(o_raw_status[8:1])) == 8'hff
            || $past(hw_idle_off) || $past(i_rx_full_lvl)
               != i_rx_full_lvl || $past(i_tx_empty_lvl) != i_tx_empty_lvl))
    else $error("underflow clear wrong");

  a_single_clears: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    (c_rxo && !i_rx_over_evt |=> !o_raw_status[1])
    and (c_txo && !i_tx_over_evt |=> !o_raw_status[3])
    and (c_rdq && !i_rd_req_evt |=> !o_raw_status[5])
    and (c_rxd && !i_rx_done_evt |=> !o_raw_status[7]))
    else $error("single clear missed its bit");

  a_abort_flag_clr: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    c_abt && !i_abort_evt |=> !o_raw_status[6])
    else $error("abort flag not cleared");

  a_flush_release: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    abt_wipe && !i_abort_evt |=> !o_tx_flush_hold)
    else $error("flush hold not released");

  a_flush_set: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    i_abort_evt |=> o_tx_flush_hold)
    else $error("flush hold not raised");

  a_flush_keeps: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_tx_flush_hold && !abt_wipe |=> o_tx_flush_hold)
    else $error("flush hold dropped early");

  a_act_stays: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    c_act && i_bus_active |=> o_raw_status[8])
    else $error("activity dropped while busy");

  a_act_hw_clear: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    hw_idle_off |=> !o_raw_status[8])
    else $error("activity not self-cleared");

  a_act_readback: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    capture && a_act |=> o_avs_readdata[0] == $past(o_raw_status[8])
                       && o_avs_readdata[31:1] == 31'h00000000)
    else $error("activity readback wrong");

  a_under_sets: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    i_rx_pop && i_rx_empty |=> o_raw_status[0])
    else $error("underflow not flagged");

  a_one_wait: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest)
    else $error("bus answer late");

  a_write_inert: assert property (
    @(posedge i_mclk) disable iff (!i_reset_n)
    wr_done && !a_raw && !ev_any
    |=> (o_raw_status & 9'h0eb) == $past(o_raw_status & 9'h0eb))
    else $error("write changed status");
endmodule

// file: icr_ctl_model.sv
// behavioural controller core feeding event pulses to the clear block
module icr_ctl_model (
  // clock
  input wire logic i_mclk,
  // bench command, one bit per event
  input wire logic [5:0] i_fire,
  input wire icr_pkg::icr_word_t i_cause,
  // event pulses
  output logic o_rx_pop,
  output logic o_rx_over_evt,
  output logic o_tx_over_evt,
  output logic o_rd_req_evt,
  output logic o_rx_done_evt,
  output logic o_abort_evt,
  output icr_pkg::icr_word_t o_abort_cause
);
  import icr_pkg::*;
  initial begin
    {o_rx_pop, o_rx_over_evt, o_tx_over_evt} = 3'h0;
    {o_rd_req_evt, o_rx_done_evt, o_abort_evt} = 3'h0;
    o_abort_cause = 32'h00000000;
  end
  always @(posedge i_mclk) begin
    o_rx_pop <= i_fire[0];
    o_rx_over_evt <= i_fire[1];
    o_tx_over_evt <= i_fire[2];
    o_rd_req_evt <= i_fire[3];
    o_rx_done_evt <= i_fire[4];
    o_abort_evt <= i_fire[5];
    // cause is only meaningful with the pulse; toggle it otherwise
    o_abort_cause <= i_fire[5] ? i_cause : ~o_abort_cause;
  end
endmodule

// file: testbench.sv
// self-checking bench of the read-to-clear interrupt registers
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import icr_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  icr_addr_t address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  icr_word_t wdata = 32'h00000000;
  icr_word_t rdata;
  logic waitreq;
  logic [5:0] fire_cmd = 6'h00;
  icr_word_t cause = 32'h00000000;
  logic pop, rxo, txo, rdq, rxd, abt;
  icr_word_t abt_cause;
  logic rx_empty = 1'b0;
  logic rx_full = 1'b0;
  logic tx_empty = 1'b0;
  logic bus_active = 1'b0;
  logic enable = 1'b0;
  logic keep = 1'b0;
  icr_raw_t raw;
  icr_word_t src;
  logic flush, irq;
  int failures = 0;
  int compares = 0;
  icr_word_t q;
  always #10 i_mclk = ~i_mclk;
  icr_ctl_model icr_ctl_model_i (.i_mclk(i_mclk), .i_fire(fire_cmd),
    .i_cause(cause), .o_rx_pop(pop), .o_rx_over_evt(rxo),
    .o_tx_over_evt(txo), .o_rd_req_evt(rdq), .o_rx_done_evt(rxd),
    .o_abort_evt(abt), .o_abort_cause(abt_cause));
  icr_top icr_top_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_rx_pop(pop), .i_rx_empty(rx_empty), .i_rx_over_evt(rxo),
    .i_tx_over_evt(txo), .i_rd_req_evt(rdq), .i_rx_done_evt(rxd),
    .i_abort_evt(abt), .i_abort_cause(abt_cause),
    .i_rx_full_lvl(rx_full), .i_tx_empty_lvl(tx_empty),
    .i_bus_active(bus_active), .i_enable(enable),
    .i_abort_keep_cause(keep), .o_raw_status(raw),
    .o_abort_source(src), .o_tx_flush_hold(flush), .o_irq(irq));

  task automatic stop_test();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input icr_word_t got, input icr_word_t exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // request held until an edge sees waitrequest low, released at that edge
  task automatic bus(input logic w, input icr_addr_t a, input icr_word_t d);
    int n;
    n = 0;
    @(posedge i_mclk);
    address <= a;
    wdata <= d;
    read <= ~w;
    write <= w;
    do begin
      @(posedge i_mclk);
      n++;
      if (n > 20) begin
        failures++;
        $display("MISMATCH t=%0t bus wait ran out", $time);
        stop_test();
      end
    end while (waitreq !== 1'b0);
    q = rdata;
    read <= 1'b0;
    write <= 1'b0;
    @(negedge i_mclk);
  endtask

  // pulse reaches the block two edges on, status lands one edge later
  task automatic fire(input logic [5:0] v);
    @(posedge i_mclk);
    fire_cmd <= v;
    @(posedge i_mclk);
    fire_cmd <= 6'h00;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask

  function automatic icr_word_t w9(input icr_raw_t r);
    return {23'h000000, r};
  endfunction

  task automatic t_reset();
    chk(w9(raw) | src | {30'h0, flush, irq}, 32'h0, "reset");
    for (int a = 8'h40; a <= 8'h5c; a += 4) begin
      bus(1'b0, icr_addr_t'(a), 32'h0);
      chk(q, 32'h0, "clear reg after reset");
    end
    bus(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0, "unmapped read");
  endtask

  task automatic t_single();
    icr_addr_t offs [5] = '{8'h44, 8'h48, 8'h4c, 8'h50, 8'h58};
    int bits [5] = '{0, 1, 3, 5, 7};
    icr_word_t e;
    @(posedge i_mclk);
    rx_empty <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      fire(6'h1f);
      chk(w9(raw), 32'h0ab, "events set");
      chk({31'h0, irq}, 32'h0, "masked irq");
      bus(1'b0, offs[i], 32'h0);
      chk(q, 32'h1, "clear read value");
      e = 32'h0ab & ~(32'h1 << bits[i]);
      chk(w9(raw), e, "one cleared");
    end
    bus(1'b1, 8'h44, 32'hffffffff);
    chk(w9(raw), 32'h02b, "write leaves status");
    bus(1'b0, 8'h44, 32'h0);
    @(posedge i_mclk);
    rx_empty <= 1'b0;
    fire(6'h01);
    chk(w9(raw), 32'h02a, "pop of filled buffer");
  endtask

  task automatic t_abort();
    bus(1'b1, 8'h84, 32'h00000040);
    @(posedge i_mclk);
    rx_full <= 1'b1;
    tx_empty <= 1'b1;
    keep <= 1'b1;
    rx_empty <= 1'b1;
    cause <= 32'h00000201;
    fire(6'h20);
    chk({30'h0, flush, irq}, 32'h3, "abort raises hold and irq");
    chk(src, 32'h00000201, "abort cause");
    bus(1'b0, 8'h54, 32'h0);
    chk(q, 32'h1, "abort clear value");
    chk(w9(raw), 32'h03e, "abort bit cleared");
    chk(src, 32'h00000200, "bit 9 survives");
    chk({30'h0, flush, irq}, 32'h0, "hold released");
    @(posedge i_mclk);
    keep <= 1'b0;
    fire(6'h3f);
    chk(w9(raw), 32'h0ff, "all events set");
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h1, "clear-all reads irq");
    chk(w9(raw), 32'h014, "levels untouched");
    chk(src, 32'h0, "source wiped");
    chk({30'h0, flush, irq}, 32'h0, "irq dropped");
    @(posedge i_mclk);
    rx_full <= 1'b0;
    tx_empty <= 1'b0;
  endtask

  task automatic t_activity();
    @(posedge i_mclk);
    enable <= 1'b1;
    bus_active <= 1'b1;
    repeat (3) @(posedge i_mclk);
    bus(1'b0, 8'h5c, 32'h0);
    chk(q, 32'h1, "activity read value");
    chk({31'h0, raw[8]}, 32'h1, "flag kept while active");
    @(posedge i_mclk);
    bus_active <= 1'b0;
    bus(1'b0, 8'h5c, 32'h0);
    chk(q, 32'h1, "activity value when idle");
    chk({31'h0, raw[8]}, 32'h0, "flag cleared when idle");
    @(posedge i_mclk);
    bus_active <= 1'b1;
    @(posedge i_mclk);
    bus_active <= 1'b0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({31'h0, raw[8]}, 32'h1, "no self clear while enabled");
    @(posedge i_mclk);
    enable <= 1'b0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({31'h0, raw[8]}, 32'h0, "self clear when disabled");
    bus(1'b0, 8'h5c, 32'h0);
    chk(q, 32'h0, "activity value cleared");
  endtask

  // raw write-one-clear touches stored bits only; mask reads back
  task automatic t_own_regs();
    @(posedge i_mclk);
    tx_empty <= 1'b1;
    fire(6'h02);
    bus(1'b1, 8'h80, 32'h000001ff);
    bus(1'b0, 8'h80, 32'h0);
    chk(q, 32'h010, "raw write keeps levels");
    bus(1'b0, 8'h84, 32'h0);
    chk(q, 32'h040, "mask readback");
    @(posedge i_mclk);
    tx_empty <= 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(negedge i_mclk);
    t_reset();
    t_single();
    t_abort();
    t_activity();
    t_own_regs();
    stop_test();
  end
endmodule
